// ---- src/pmbrc_pkg.sv ----
// =====================================================================
// Shared constants for the rail configuration bank
package pmbrc_pkg;
  localparam int NPAGE = 2;

  // =====================================================================
  // Command codes and reset values
  localparam logic [7:0]  CMD_SLEW  = 8'h27;
  localparam logic [7:0]  CMD_DROOP = 8'h28;
  localparam logic [7:0]  CMD_FREQ  = 8'h33;
  localparam logic [7:0]  CMD_ILV   = 8'h37;
  localparam logic [7:0]  CMD_GAIN  = 8'h38;
  localparam logic [7:0]  CMD_OFS   = 8'h39;
  localparam logic [15:0] RST_SLEW  = 16'hBA00;
  localparam logic [15:0] RST_GAIN  = 16'hB2AE;
  localparam logic [15:0] RST_OFS   = 16'hBD00;
  // Largest positive exponent/mantissa pair means move at once
  localparam logic [15:0] SLEW_FASTEST = 16'h7BFF;

  // =====================================================================
  // Linear-11 layout and fixed-point scaling
  localparam int LIN_EXP_LSB = 11;
  localparam int LIN_EXP_MAX = 20;
  localparam int FX_FRAC     = 8;
  localparam int SLEW_MIN_FX = 26;
  localparam int SLEW_MAX_FX = 1024;
  localparam int DROOP_MAX_FX = 10240;
  localparam int IOUT_FRAC   = 4;
  localparam int DROOP_SHIFT = FX_FRAC + IOUT_FRAC;

  // =====================================================================
  // Timing: one setpoint step per threshold of accumulated rate
  localparam int CLK_MHZ        = 125;
  localparam int CLK_KHZ        = CLK_MHZ * 1000;
  localparam int VOUT_LSB_PER_V = 8192;
  localparam int STEP_THRESH    =
    (1 << FX_FRAC) * CLK_KHZ / VOUT_LSB_PER_V;

  // =====================================================================
  // Switching rate divider
  localparam int FSW_BASE_KHZ = 16000;
  localparam int DIV_MIN      = 12;
  localparam int DIV_MAX      = 80;
  localparam int FSW_MIN_KHZ  = 200;
  localparam int FSW_MAX_KHZ  = 1333;

  // =====================================================================
  // Phase placement fields, slots of 22.5 degrees
  localparam int         ILV_CNT_LSB = 4;
  localparam int         ILV_POS_LSB = 0;
  localparam int         ILV_FLD_W   = 4;
  localparam logic [4:0] ILV_ZERO_AS = 5'h10;
  localparam int         SLOTS_360   = 16;
  localparam int         SLOTS_180   = 8;

  typedef enum logic [2:0] {
    PMBRC_IDLE   = 3'b001,
    PMBRC_SLEW   = 3'b010,
    PMBRC_FOLLOW = 3'b100
  } pmbrc_slew_t;
endpackage : pmbrc_pkg

// ---- src/pmbrc_regs.sv ----
`timescale 1ns/100ps
module pmbrc_regs (
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  input  wire logic                      ce,
  input  wire logic                      cmd_valid,
  input  wire logic                      cmd_write,
  input  wire logic                      cmd_page,
  input  wire logic [7:0]                cmd_code,
  input  wire logic [15:0]               cmd_wdata,
  input  wire logic                      write_protect,
  output logic                           rsp_valid,
  output logic [15:0]                    rsp_rdata,
  output logic                           rsp_err,
  input  wire logic [15:0]               cfg_droop_strap,
  input  wire logic [15:0]               cfg_ilv_strap,
  input  wire logic [15:0]               sync_freq_strap,
  input  wire logic [1:0][15:0]          vout_target,
  input  wire logic [1:0]                soft_ramp,
  input  wire logic [1:0]                output_on,
  input  wire logic [1:0][15:0]          iout_sense,
  output logic [1:0][15:0]               vout_setpoint,
  output logic [1:0][15:0]               droop_mv,
  output logic [1:0][4:0]                phase0_slot,
  output logic [1:0][4:0]                phase1_slot,
  output logic [6:0]                     switching_rate_div,
  output logic [1:0][15:0]               cal_gain,
  output logic [1:0][15:0]               cal_offset
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // =====================================================================
  // Helpers
  // Shift is capped so a huge exponent saturates instead of wrapping
  function automatic int pmbrc_lin11(input logic [15:0] w, input int fr);
    int m;
    int e;
    m = int'(signed'(w[pmbrc_pkg::LIN_EXP_LSB-1:0]));
    e = int'(signed'(w[15:pmbrc_pkg::LIN_EXP_LSB])) + fr;
    if (e > pmbrc_pkg::LIN_EXP_MAX)
      e = pmbrc_pkg::LIN_EXP_MAX;
    if (e >= 0)
      return m <<< e;
    return m >>> (-e);
  endfunction : pmbrc_lin11

  function automatic int pmbrc_clamp(input int v, input int lo,
                                     input int hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : pmbrc_clamp

  function automatic logic pmbrc_known(input logic [7:0] c);
    return c inside {pmbrc_pkg::CMD_SLEW, pmbrc_pkg::CMD_DROOP,
                     pmbrc_pkg::CMD_FREQ, pmbrc_pkg::CMD_ILV,
                     pmbrc_pkg::CMD_GAIN, pmbrc_pkg::CMD_OFS};
  endfunction : pmbrc_known

  // Anything past a full turn folds back by whole turns
  function automatic logic [4:0] pmbrc_wrap(input int s);
    if (s > pmbrc_pkg::SLOTS_360)
      return 5'((s - 1) % pmbrc_pkg::SLOTS_360 + 1);
    return 5'(s);
  endfunction : pmbrc_wrap

  // =====================================================================
  // Strap synchronisers; straps are pins, so two flops first
  logic [2:0][15:0] strap_s1;
  logic [2:0][15:0] strap_s2;
  always_ff @(posedge clk)
  begin
    strap_s1 <= {sync_freq_strap, cfg_ilv_strap, cfg_droop_strap};
    strap_s2 <= strap_s1;
  end

  // =====================================================================
  // Register storage; frequency is one word shared by both pages
  logic [1:0][15:0] slew;
  logic [1:0][15:0] droop;
  logic [1:0][15:0] ilv;
  logic [15:0]      freq;
  wire              wr_ok = cmd_valid & cmd_write & ~write_protect &
                            pmbrc_known(cmd_code);

  // Protected writes leave every register untouched
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      slew       <= {2{pmbrc_pkg::RST_SLEW}};
      droop      <= {2{strap_s2[0]}};
      ilv        <= {2{strap_s2[1]}};
      freq       <= strap_s2[2];
      cal_gain   <= {2{pmbrc_pkg::RST_GAIN}};
      cal_offset <= {2{pmbrc_pkg::RST_OFS}};
    end
    else if (ce && wr_ok)
    begin
      case (cmd_code)
        pmbrc_pkg::CMD_SLEW:  slew[cmd_page]       <= cmd_wdata;
        pmbrc_pkg::CMD_DROOP: droop[cmd_page]      <= cmd_wdata;
        pmbrc_pkg::CMD_FREQ:  freq                 <= cmd_wdata;
        pmbrc_pkg::CMD_ILV:   ilv[cmd_page]        <= cmd_wdata;
        pmbrc_pkg::CMD_GAIN:  cal_gain[cmd_page]   <= cmd_wdata;
        pmbrc_pkg::CMD_OFS:   cal_offset[cmd_page] <= cmd_wdata;
        default:              slew                 <= slew;
      endcase
    end
  end

  // =====================================================================
  // Read selection and response
  wire [15:0] rd_val =
    (cmd_code == pmbrc_pkg::CMD_SLEW)  ? slew[cmd_page] :
    (cmd_code == pmbrc_pkg::CMD_DROOP) ? droop[cmd_page] :
    (cmd_code == pmbrc_pkg::CMD_FREQ)  ? freq :
    (cmd_code == pmbrc_pkg::CMD_ILV)   ? ilv[cmd_page] :
    (cmd_code == pmbrc_pkg::CMD_GAIN)  ? cal_gain[cmd_page] :
    (cmd_code == pmbrc_pkg::CMD_OFS)   ? cal_offset[cmd_page] : 16'h0000;
  wire rd_bad = ~pmbrc_known(cmd_code) | (cmd_write & write_protect);

  // Answer one cycle after the request
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rsp_valid <= 1'b0;
      rsp_rdata <= 16'h0000;
      rsp_err   <= 1'b0;
    end
    else if (ce)
    begin
      rsp_valid <= cmd_valid;
      rsp_rdata <= (cmd_valid & ~cmd_write) ? rd_val : 16'h0000;
      rsp_err   <= cmd_valid & rd_bad;
    end
  end

  // =====================================================================
  // Switching rate divider; out-of-range kHz is clamped, never refused
  int fkhz;
  int ndiv;
  assign fkhz = pmbrc_clamp(pmbrc_lin11(freq, 0), pmbrc_pkg::FSW_MIN_KHZ,
                            pmbrc_pkg::FSW_MAX_KHZ);
  assign ndiv = pmbrc_clamp((pmbrc_pkg::FSW_BASE_KHZ + fkhz / 2) / fkhz,
                            pmbrc_pkg::DIV_MIN, pmbrc_pkg::DIV_MAX);

  // Divider loads in reset; otherwise it only moves while both outputs are off, never mid-switching
  always_ff @(posedge clk)
  begin
    if (sys_rst || (ce && output_on == 2'b00))
      switching_rate_div <= 7'(ndiv);
  end

  chk_div_range: assert property (
    switching_rate_div >= 7'(pmbrc_pkg::DIV_MIN) &&
    switching_rate_div <= 7'(pmbrc_pkg::DIV_MAX))
    else $error("switching divider out of range");

  sequence s_rst_end;
    $fell(sys_rst);
  endsequence

  chk_slew_reset: assert property (
    s_rst_end |-> slew == {2{pmbrc_pkg::RST_SLEW}})
    else $error("slew register reset value wrong");
  chk_cal_reset: assert property (
    s_rst_end |-> cal_gain == {2{pmbrc_pkg::RST_GAIN}} &&
                  cal_offset == {2{pmbrc_pkg::RST_OFS}})
    else $error("current calibration reset value wrong");
  chk_strap_load: assert property (
    s_rst_end |-> droop[0] == $past(strap_s2[0]) &&
                  freq == $past(strap_s2[2]))
    else $error("strap default not loaded");
  chk_wp_block: assert property (
    ce && cmd_valid && cmd_write && write_protect
    |=> slew == $past(slew) && freq == $past(freq) &&
        cal_gain == $past(cal_gain))
    else $error("write landed while protected");

  // =====================================================================
  // Per-page slew engine, load line and phase placement
  genvar g;
  generate
    for (g = 0; g < pmbrc_pkg::NPAGE; g++)
    begin : g_page
      pmbrc_pkg::pmbrc_slew_t st;
      pmbrc_pkg::pmbrc_slew_t next_st;
      logic [15:0]            next_sp;
      logic [12:0]            acc;
      logic [12:0]            next_acc;
      int                     rate_fx;
      int                     sum;
      int                     prod;
      int                     slot_raw;
      logic [4:0]             cnt;
      logic [4:0]             pos;
      wire                    fast = (slew[g] == pmbrc_pkg::SLEW_FASTEST);
      wire [15:0]             sp   = vout_setpoint[g];
      wire [15:0]             tgt  = vout_target[g];

      // Rate held inside 0.1..4 V/ms, scaled by two^FX_FRAC
      assign rate_fx = pmbrc_clamp(pmbrc_lin11(slew[g], pmbrc_pkg::FX_FRAC),
        pmbrc_pkg::SLEW_MIN_FX, pmbrc_pkg::SLEW_MAX_FX);
      assign sum = int'(acc) + rate_fx;

      // Accumulator trades a divider for one compare per cycle
      always_comb
      begin
        next_st  = st;
        next_sp  = sp;
        next_acc = acc;
        case (st)
          pmbrc_pkg::PMBRC_IDLE:
            if (soft_ramp[g])
              next_st = pmbrc_pkg::PMBRC_FOLLOW;
            else if (tgt != sp && fast)
              next_sp = tgt;
            else if (tgt != sp)
              next_st = pmbrc_pkg::PMBRC_SLEW;
          pmbrc_pkg::PMBRC_SLEW:
            if (soft_ramp[g])
              next_st = pmbrc_pkg::PMBRC_FOLLOW;
            else if (tgt == sp)
            begin
              next_st  = pmbrc_pkg::PMBRC_IDLE;
              next_acc = 13'h0000;
            end
            else if (fast)
              next_sp = tgt;
            else if (sum >= pmbrc_pkg::STEP_THRESH)
            begin
              next_acc = 13'(sum - pmbrc_pkg::STEP_THRESH);
              next_sp  = (tgt > sp) ? sp + 16'h0001
                                    : sp - 16'h0001;
            end
            else
              next_acc = 13'(sum);
          pmbrc_pkg::PMBRC_FOLLOW:
          begin
            next_sp = tgt;
            if (!soft_ramp[g])
            begin
              next_st  = pmbrc_pkg::PMBRC_IDLE;
              next_acc = 13'h0000;
            end
          end
          default: next_st = pmbrc_pkg::PMBRC_IDLE;
        endcase
      end

      // Load line: mV = slope * amps; sign carries through for sinking
      assign prod = pmbrc_clamp(pmbrc_lin11(droop[g], pmbrc_pkg::FX_FRAC),
        0, pmbrc_pkg::DROOP_MAX_FX) * int'(signed'(iout_sense[g]));

      // Zero in a field stands for sixteen
      assign cnt = (ilv[g][pmbrc_pkg::ILV_CNT_LSB +: pmbrc_pkg::ILV_FLD_W]
                    == 4'h0) ? pmbrc_pkg::ILV_ZERO_AS
        : {1'b0, ilv[g][pmbrc_pkg::ILV_CNT_LSB +: pmbrc_pkg::ILV_FLD_W]};
      assign pos = (ilv[g][pmbrc_pkg::ILV_POS_LSB +: pmbrc_pkg::ILV_FLD_W]
                    == 4'h0) ? pmbrc_pkg::ILV_ZERO_AS
        : {1'b0, ilv[g][pmbrc_pkg::ILV_POS_LSB +: pmbrc_pkg::ILV_FLD_W]};
      assign slot_raw = (int'(pos) * pmbrc_pkg::SLOTS_360 + int'(cnt) / 2)
                        / int'(cnt);

      always_ff @(posedge clk)
      begin
        if (sys_rst)
        begin
          st               <= pmbrc_pkg::PMBRC_IDLE;
          acc              <= 13'h0000;
          vout_setpoint[g] <= 16'h0000;
          droop_mv[g]      <= 16'h0000;
          phase0_slot[g]   <= 5'h00;
          phase1_slot[g]   <= 5'h00;
        end
        else if (ce)
        begin
          st               <= next_st;
          acc              <= next_acc;
          vout_setpoint[g] <= next_sp;
          droop_mv[g] <= 16'(prod >>> pmbrc_pkg::DROOP_SHIFT);
          phase0_slot[g]   <= pmbrc_wrap(slot_raw);
          phase1_slot[g]   <= pmbrc_wrap(int'(pmbrc_wrap(slot_raw)) +
                                         pmbrc_pkg::SLOTS_180);
        end
      end

      sequence s_ramp2;
        ce && soft_ramp[g] ##1 ce && soft_ramp[g];
      endsequence

      chk_ramp_follow: assert property (
        s_ramp2 |=> vout_setpoint[g] == $past(vout_target[g]))
        else $error("setpoint did not follow during ramp");
      chk_fast_jump: assert property (
        ce && st == pmbrc_pkg::PMBRC_IDLE && !soft_ramp[g] && fast &&
        tgt != sp |=> vout_setpoint[g] == $past(vout_target[g]))
        else $error("fastest rate did not jump");
      chk_slew_step: assert property (
        ce && st == pmbrc_pkg::PMBRC_SLEW && !fast && !soft_ramp[g]
        |=> vout_setpoint[g] == $past(sp) ||
            vout_setpoint[g] == $past(sp) + 16'h0001 ||
            vout_setpoint[g] == $past(sp) - 16'h0001)
        else $error("slewing setpoint moved more than one step");
      chk_droop_sign: assert property (
        ce && signed'(iout_sense[g]) < 0
        |=> signed'(droop_mv[g]) <= 0)
        else $error("sinking current produced positive droop");
      chk_phase_180: assert property (
        ce |=> 4'(phase1_slot[g] - phase0_slot[g]) == 4'h8 &&
        phase0_slot[g] <= 5'h10 && phase0_slot[g] != 5'h00)
        else $error("second phase not half a turn after first");
    end
  endgenerate
endmodule : pmbrc_regs

// ---- sim/pmbrc_host_model.sv ----
`timescale 1ns/100ps
// =====================================================================
// Host side of the command port
module pmbrc_host_model (
  input  wire logic        clk,
  input  wire logic [1:0]  output_on,
  input  wire logic        rsp_valid,
  input  wire logic [15:0] rsp_rdata,
  input  wire logic        rsp_err,
  output logic             cmd_valid,
  output logic             cmd_write,
  output logic             cmd_page,
  output logic [7:0]       cmd_code,
  output logic [15:0]      cmd_wdata
);
  // Idle strobe low from time zero
  initial
  begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_page  = 1'b0;
    cmd_code  = 8'h00;
    cmd_wdata = 16'h0000;
  end

  // One request; answer taken at the edge after the taking edge
  task automatic xfer(input logic w, input logic pg, input logic [7:0] c,
                      input logic [15:0] d, output logic v,
                      output logic [15:0] rd, output logic e);
    @(posedge clk);
    v  = 1'b0;
    rd = 16'h0000;
    e  = 1'b1;
    // Never retune the switcher with a rail running
    if (w && c == pmbrc_pkg::CMD_FREQ && output_on != 2'b00)
      return;
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_page  <= pg;
    cmd_code  <= c;
    cmd_wdata <= d;
    @(posedge clk);
    // Released lines scrambled so stale data cannot look valid
    cmd_valid <= 1'b0;
    cmd_code  <= ~c;
    cmd_wdata <= ~d;
    // Answer stands until this edge; read before it is replaced
    @(posedge clk);
    v  = rsp_valid;
    rd = rsp_rdata;
    e  = rsp_err;
  endtask : xfer
endmodule : pmbrc_host_model

// ---- sim/pmbrc_regs_tb.sv ----
`timescale 1ns/100ps
module pmbrc_regs_tb;
  logic clk = 1'b0, sys_rst = 1'b1, ce = 1'b1, wp = 1'b0;
  logic cv, cw, cp, rv, re;
  logic [7:0] cc;
  logic [15:0] cd, rr, s_droop, s_ilv, s_freq;
  logic [1:0][15:0] tgt, iout, setp, drp, gain, ofs;
  logic [1:0] ramp = 2'b00, on = 2'b00;
  logic [1:0][4:0] ph0, ph1;
  logic [6:0] div;
  logic [31:0] seed = 32'h9564DF31;
  int fail_count = 0, n_checks = 0, cycles = 0;

  always #4 clk = ~clk;

  pmbrc_host_model u_pmbrc_host_model (.clk(clk), .output_on(on),
    .rsp_valid(rv), .rsp_rdata(rr), .rsp_err(re), .cmd_valid(cv),
    .cmd_write(cw), .cmd_page(cp), .cmd_code(cc), .cmd_wdata(cd));

  pmbrc_regs u_pmbrc_regs (.clk(clk), .sys_rst(sys_rst), .ce(ce),
    .cmd_valid(cv), .cmd_write(cw), .cmd_page(cp), .cmd_code(cc),
    .cmd_wdata(cd), .write_protect(wp), .rsp_valid(rv), .rsp_rdata(rr),
    .rsp_err(re), .cfg_droop_strap(s_droop), .cfg_ilv_strap(s_ilv),
    .sync_freq_strap(s_freq), .vout_target(tgt), .soft_ramp(ramp),
    .output_on(on), .iout_sense(iout), .vout_setpoint(setp),
    .droop_mv(drp), .phase0_slot(ph0), .phase1_slot(ph1),
    .switching_rate_div(div), .cal_gain(gain), .cal_offset(ofs));

  // =====================================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // Divider from a kHz word with a non-negative exponent
  function automatic logic [6:0] exp_div(input logic [15:0] w);
    int f, n;
    f = int'($signed(w[10:0])) <<< w[15:11];
    f = (f < 200) ? 200 : (f > 1333) ? 1333 : f;
    n = (16000 + f / 2) / f;
    n = (n < 12) ? 12 : (n > 80) ? 80 : n;
    return 7'(n);
  endfunction : exp_div

  // Slot of 22.5 degrees; zero fields stand for 16, wrap past a turn
  function automatic logic [4:0] exp_slot(input logic [7:0] v, input int a);
    int c, p, s;
    c = (v[7:4] == 4'h0) ? 16 : int'(v[7:4]);
    p = (v[3:0] == 4'h0) ? 16 : int'(v[3:0]);
    s = (p * 32 + c) / (2 * c) + a;
    while (s > 16)
      s = s - 16;
    return 5'(s);
  endfunction : exp_slot

  task automatic check(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic wr(input logic pg, input logic [7:0] c,
                    input logic [15:0] d, input logic ee);
    logic v, e;
    logic [15:0] r;
    u_pmbrc_host_model.xfer(1'b1, pg, c, d, v, r, e);
    check("write err", {v, e}, {1'b1, ee});
  endtask : wr

  task automatic rd(input string nm, input logic pg, input logic [7:0] c,
                    input logic [15:0] exp, input logic ee);
    logic v, e;
    logic [15:0] r;
    u_pmbrc_host_model.xfer(1'b0, pg, c, 16'h0000, v, r, e);
    check(nm, {r[14:0], e}, {exp[14:0], ee});
    check(nm, r, exp);
  endtask : rd

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run

  // Hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      fail_count++;
      complete_run();
    end
  end

  // =====================================================================
  // Scenarios
  localparam logic [7:0] PG_CODE [5] = '{8'h27, 8'h28, 8'h37, 8'h39, 8'h38};
  localparam logic [15:0] FREQ_W [6] =
    '{16'h01F4, 16'h13E8, 16'h0064, 16'h00C8, 16'h0535, 16'h09F4};
  initial
  begin
    logic [15:0] a, b;
    int s, i;
    s_droop <= 16'(rnd());
    s_ilv   <= 16'(rnd());
    s_freq  <= 16'h01F4;
    tgt     <= '0;
    iout    <= '0;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    for (int p = 0; p < 2; p++)
    begin
      rd("slew rst", p, pmbrc_pkg::CMD_SLEW, 16'hBA00, 1'b0);
      rd("gain rst", p, pmbrc_pkg::CMD_GAIN, 16'hB2AE, 1'b0);
      rd("ofs rst", p, pmbrc_pkg::CMD_OFS, 16'hBD00, 1'b0);
      rd("droop rst", p, pmbrc_pkg::CMD_DROOP, s_droop, 1'b0);
      rd("ilv rst", p, pmbrc_pkg::CMD_ILV, s_ilv, 1'b0);
      rd("freq rst", p, pmbrc_pkg::CMD_FREQ, s_freq, 1'b0);
    end
    check("div rst", div, 7'h20);
    check("gain rst port", gain[0], 16'hB2AE);
    check("ofs rst port", ofs[1], 16'hBD00);
    // Paged words keep separate values
    for (int k = 0; k < 5; k++)
    begin
      a = 16'(rnd());
      b = ~a;
      wr(1'b0, PG_CODE[k], a, 1'b0);
      wr(1'b1, PG_CODE[k], b, 1'b0);
      rd("page0", 1'b0, PG_CODE[k], a, 1'b0);
      rd("page1", 1'b1, PG_CODE[k], b, 1'b0);
    end
    check("gain port", gain[1], b);
    // Protected write refused and unknown code flagged
    @(posedge clk);
    wp <= 1'b1;
    wr(1'b1, pmbrc_pkg::CMD_GAIN, 16'h1234, 1'b1);
    wp <= 1'b0;
    rd("protect", 1'b1, pmbrc_pkg::CMD_GAIN, b, 1'b0);
    check("gain hold", gain[1], b);
    rd("unknown", 1'b0, 8'h30, 16'h0000, 1'b1);
    // Frequency is global; divider only from allowed set
    for (int k = 0; k < 6; k++)
    begin
      wr(k[0], pmbrc_pkg::CMD_FREQ, FREQ_W[k], 1'b0);
      rd("global", ~k[0], pmbrc_pkg::CMD_FREQ, FREQ_W[k], 1'b0);
      repeat (3) @(posedge clk);
      check("divider", div, exp_div(FREQ_W[k]));
      check("range", 16'(div inside {[7'h0C:7'h50]}), 16'h0001);
    end
    // Phase placement: corners then random
    for (i = 0; i < 12; i++)
    begin
      a = (i == 0) ? 16'h0000 : (i == 1) ? 16'h0041 : 16'(rnd() & 8'hFF);
      wr(i[0], pmbrc_pkg::CMD_ILV, a, 1'b0);
      repeat (3) @(posedge clk);
      check("slot0", ph0[i[0]], exp_slot(a[7:0], 0));
      check("slot1", ph1[i[0]], exp_slot(a[7:0], 8));
    end
    // Both pages given the same placement word, as a group member must
    wr(1'b0, pmbrc_pkg::CMD_ILV, a, 1'b0);
    repeat (3) @(posedge clk);
    check("same slot0", ph0[0], exp_slot(a[7:0], 0));
    check("same slot1", ph0[1], exp_slot(a[7:0], 0));
    // Load line, both signs of current, clamp above 40
    for (i = 0; i < 8; i++)
    begin
      s = (i == 0) ? 50 : int'(rnd() % 41);
      a = 16'((int'(rnd() % 64) - 32) * 16);
      wr(i[0], pmbrc_pkg::CMD_DROOP, 16'(s), 1'b0);
      iout[i[0]] <= a;
      repeat (4) @(posedge clk);
      s = (s > 40) ? 40 : s;
      check("droop", drp[i[0]], 16'(s * ($signed(a) / 16)));
    end
    // Fastest setting tracks the target at once
    wr(1'b0, pmbrc_pkg::CMD_SLEW, pmbrc_pkg::SLEW_FASTEST, 1'b0);
    tgt[0] <= 16'h2000;
    repeat (4) @(posedge clk);
    check("fast", setp[0], 16'h2000);
    // One volt per ms needs about 15 cycles per step
    wr(1'b0, pmbrc_pkg::CMD_SLEW, 16'hBA00, 1'b0);
    tgt[0] <= 16'h2004;
    repeat (6) @(posedge clk);
    check("slewing", setp[0], 16'h2000);
    repeat (100) @(posedge clk);
    check("slewed", setp[0], 16'h2004);
    // Ramps ignore the programmed rate
    ramp <= 2'b01;
    tgt[0] <= 16'h2400;
    repeat (5) @(posedge clk);
    check("ramp", setp[0], 16'h2400);
    complete_run();
  end
endmodule : pmbrc_regs_tb
